// >>> pkg/sssp_pkg.sv
package sssp_pkg;

   // -------------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] SSSP_OFS_CTRL = 8'he7;
   localparam logic [7:0] SSSP_OFS_DATA = 8'he8;
   localparam logic [7:0] SSSP_OFS_DIV  = 8'he9;
   localparam logic [7:0] SSSP_OFS_STAT = 8'hea;
   localparam logic [7:0] SSSP_OFS_MASK = 8'heb;

   // -------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] SSSP_RST_CTRL = 8'h00;
   localparam logic [7:0] SSSP_RST_DATA = 8'h00;
   localparam logic [7:0] SSSP_RST_DIV  = 8'h00;
   localparam logic [7:0] SSSP_RST_STAT = 8'h00;
   localparam logic [7:0] SSSP_RST_MASK = 8'h00;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int SSSP_CTL_SRC   = 7; // 1: external shift clock
   localparam int SSSP_CTL_LSB   = 6; // 1: lsb first
   localparam int SSSP_CTL_TXRX  = 5; // 1: transmit and receive
   localparam int SSSP_CTL_EDGE  = 4; // 1: drive rising, sample falling
   localparam int SSSP_CTL_START = 3; // write 1: clear counter, start
   localparam int SSSP_CTL_SEN   = 2; // shifter and counter enable
   localparam int SSSP_CTL_IEN   = 1; // interrupt enable
   localparam int SSSP_CTL_PEND  = 0; // completion pending
   localparam int SSSP_STAT_DONE = 0; // transfer finished
   localparam int SSSP_STAT_LOST = 1; // buffer write refused while busy

   // -------------------------------------------------------------------
   // timing counts
   // -------------------------------------------------------------------
   localparam int SSSP_PRE_DIV   = 4;  // fixed system clock pre-division
   localparam int SSSP_HALF      = SSSP_PRE_DIV / 2;
   localparam logic [2:0] SSSP_LAST_BIT = 3'h7;

   // -------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------
   typedef struct packed {
      logic src_ext;
      logic lsb_first;
      logic txrx;
      logic edge_sel;
      logic start;
      logic shift_en;
      logic irq_en;
      logic pend;
   } sssp_ctl_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sssp_bus_s;

   typedef enum logic {
      SSSP_IDLE,
      SSSP_SHIFT
   } sssp_state_e;

endpackage : sssp_pkg

// >>> core/sssp_clkgen.sv
`timescale 1ns/10ps
`default_nettype none
module sssp_clkgen
   import sssp_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       srst,
   // control
   input  wire logic       run,
   input  wire logic       idle_lvl,
   input  wire logic [7:0] divider,
   // generated clock
   output logic            sck,
   output logic            rise,
   output logic            fall
);

   logic [8:0] cnt;
   logic [8:0] next_cnt;
   logic       next_sck;
   logic [8:0] half_last;
   logic       wrap;

   // -------------------------------------------------------------------
   // half period is 2*(divider+1) system clocks
   // -------------------------------------------------------------------
   assign half_last = {divider, 1'b0} + 9'(SSSP_HALF - 1);
   assign wrap      = run && (cnt == half_last);
   assign rise      = wrap && !sck;
   assign fall      = wrap && sck;

   // next counter and clock level; parked at idle level when stopped
   always_comb begin
      next_cnt = cnt + 9'h001;
      next_sck = sck;
      if (!run) begin
         next_cnt = 9'h000;
         next_sck = idle_lvl;
      end else if (wrap) begin
         next_cnt = 9'h000;
         next_sck = !sck;
      end
   end

   // register stage
   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt <= 9'h000;
         sck <= 1'b1;
      end else begin
         cnt <= next_cnt;
         sck <= next_sck;
      end
   end

endmodule : sssp_clkgen
`default_nettype wire

// >>> core/sssp_core.sv
`timescale 1ns/10ps
`default_nettype none
module sssp_core
   import sssp_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       srst,
   // register port
   input  wire sssp_bus_s  bus,
   output logic [7:0]      rdata,
   // serial pins
   input  wire logic       si_in,
   input  wire logic       sck_in,
   output logic            sck_out,
   output logic            sck_oe_n,
   output logic            so_out,
   // interrupt
   output logic            irq
);

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   sssp_ctl_s   ctl;
   sssp_ctl_s   next_ctl;
   sssp_state_e state;
   sssp_state_e next_state;
   logic [7:0]  buffer;
   logic [7:0]  next_buffer;
   logic [7:0]  div;
   logic [7:0]  next_div;
   logic [2:0]  cnt;
   logic [2:0]  next_cnt;
   logic [7:0]  evt;
   logic [7:0]  next_evt;
   logic [7:0]  mask;
   logic [7:0]  next_mask;
   logic        so_q;
   logic        next_so_q;
   logic [7:0]  next_rdata;
   logic        si_s1;
   logic        si_s2;
   logic        sck_s1;
   logic        sck_s2;
   logic        sck_s3;
   logic        next_si_s1;
   logic        next_si_s2;
   logic        next_sck_s1;
   logic        next_sck_s2;
   logic        next_sck_s3;
   logic        gen_run;
   logic        gen_sck;
   logic        gen_rise;
   logic        gen_fall;
   logic        rise_ev;
   logic        fall_ev;
   logic        active;
   logic        drive_ev;
   logic        sample_ev;
   logic        done;
   logic [7:0]  evt_set;
   logic [7:0]  evt_clr;

   // -------------------------------------------------------------------
   // decode helpers
   // -------------------------------------------------------------------
   function automatic logic bus_hit(input sssp_bus_s b,
                                    input logic [7:0] ofs);
      return b.addr == ofs;
   endfunction : bus_hit

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   // two stages for data in, a third stage for clock edge detection
   always_comb begin
      next_si_s1  = si_in;
      next_si_s2  = si_s1;
      next_sck_s1 = sck_in;
      next_sck_s2 = sck_s1;
      next_sck_s3 = sck_s2;
   end

   // clock chain resets to the pin's idle high level, so no false edge
   always_ff @(posedge mclk) begin
      if (srst) begin
         si_s1  <= 1'b0;
         si_s2  <= 1'b0;
         sck_s1 <= 1'b1;
         sck_s2 <= 1'b1;
         sck_s3 <= 1'b1;
      end else begin
         si_s1  <= next_si_s1;
         si_s2  <= next_si_s2;
         sck_s1 <= next_sck_s1;
         sck_s2 <= next_sck_s2;
         sck_s3 <= next_sck_s3;
      end
   end

   // -------------------------------------------------------------------
   // internal shift clock
   // -------------------------------------------------------------------
   // runs only while a transfer is live with the internal source
   assign gen_run = active && !ctl.src_ext;

   sssp_clkgen u_clkgen (
      .mclk     (mclk),
      .srst     (srst),
      .run      (gen_run),
      .idle_lvl (!ctl.edge_sel),
      .divider  (div),
      .sck      (gen_sck),
      .rise     (gen_rise),
      .fall     (gen_fall)
   );

   // -------------------------------------------------------------------
   // edge selection
   // -------------------------------------------------------------------
   // pick the edge source, then map edges to drive and sample
   // data in lags the pin by two clocks: a divider of 0 leaves only
   // two clocks per half period, too little setup for the sample edge
   assign rise_ev   = ctl.src_ext ? (sck_s2 && !sck_s3) : gen_rise;
   assign fall_ev   = ctl.src_ext ? (!sck_s2 && sck_s3) : gen_fall;
   assign active    = (state == SSSP_SHIFT) && ctl.shift_en;
   assign drive_ev  = active && (ctl.edge_sel ? rise_ev : fall_ev);
   assign sample_ev = active && (ctl.edge_sel ? fall_ev : rise_ev);
   assign done      = sample_ev && (cnt == SSSP_LAST_BIT);

   // -------------------------------------------------------------------
   // control, buffer and shifter
   // -------------------------------------------------------------------
   always_comb begin
      next_ctl    = ctl;
      next_state  = state;
      next_buffer = buffer;
      next_div    = div;
      next_cnt    = cnt;
      next_so_q   = so_q;

      // shift in on the sample edge, in the selected order
      if (sample_ev) begin
         next_cnt = cnt + 3'h1;
         if (ctl.lsb_first) begin
            next_buffer = {si_s2, buffer[7:1]};
         end else begin
            next_buffer = {buffer[6:0], si_s2};
         end
      end

      // drive out on the other edge, only in duplex mode
      if (drive_ev && ctl.txrx) begin
         next_so_q = ctl.lsb_first ? buffer[0] : buffer[7];
      end

      // byte framing: start arms the shifter, eighth sample parks it
      unique case (state)
         SSSP_IDLE: begin
            next_state = SSSP_IDLE;
         end
         SSSP_SHIFT: begin
            if (done) begin
               next_state = SSSP_IDLE;
            end
         end
      endcase

      // control write; start never reads back, pending only clears
      if (bus.wr && bus_hit(bus, SSSP_OFS_CTRL)) begin
         next_ctl       = sssp_ctl_s'(bus.wdata);
         next_ctl.start = 1'b0;
         next_ctl.pend  = ctl.pend && bus.wdata[SSSP_CTL_PEND];
         if (bus.wdata[SSSP_CTL_START]) begin
            next_cnt   = 3'h0;
            next_state = SSSP_SHIFT;
         end
      end

      // buffer write refused while a byte is on the wire
      if (bus.wr && bus_hit(bus, SSSP_OFS_DATA) && state == SSSP_IDLE) begin
         next_buffer = bus.wdata;
      end

      if (bus.wr && bus_hit(bus, SSSP_OFS_DIV)) begin
         next_div = bus.wdata;
      end

      // completion sets pending last so it beats a clearing write
      if (done) begin
         next_ctl.pend = 1'b1;
      end
   end

   // register control, framing, buffer and shifter
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctl    <= sssp_ctl_s'(SSSP_RST_CTRL);
         state  <= SSSP_IDLE;
         buffer <= SSSP_RST_DATA;
         div    <= SSSP_RST_DIV;
         cnt    <= 3'h0;
         so_q   <= 1'b0;
      end else begin
         ctl    <= next_ctl;
         state  <= next_state;
         buffer <= next_buffer;
         div    <= next_div;
         cnt    <= next_cnt;
         so_q   <= next_so_q;
      end
   end

   // -------------------------------------------------------------------
   // status events and mask
   // -------------------------------------------------------------------
   // events only latch while the interrupt is enabled
   always_comb begin
      next_mask = mask;
      evt_set   = 8'h00;
      evt_clr   = 8'h00;
      if (bus.wr && bus_hit(bus, SSSP_OFS_MASK)) begin
         next_mask = bus.wdata;
      end
      // a buffer write during a transfer is refused and flagged
      if (bus.wr && bus_hit(bus, SSSP_OFS_DATA) && state == SSSP_SHIFT) begin
         evt_set[SSSP_STAT_LOST] = ctl.irq_en;
      end
      if (done) begin
         evt_set[SSSP_STAT_DONE] = ctl.irq_en;
      end
      // status clears on read; a same-cycle event survives
      if (bus.rd && bus_hit(bus, SSSP_OFS_STAT)) begin
         evt_clr = evt;
      end
      next_evt = (evt & ~evt_clr) | evt_set;
   end

   // register status and mask
   always_ff @(posedge mclk) begin
      if (srst) begin
         evt  <= SSSP_RST_STAT;
         mask <= SSSP_RST_MASK;
      end else begin
         evt  <= next_evt;
         mask <= next_mask;
      end
   end

   // -------------------------------------------------------------------
   // read data, valid the cycle after the strobe
   // -------------------------------------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            SSSP_OFS_CTRL: next_rdata = ctl;
            SSSP_OFS_DATA: next_rdata = buffer;
            SSSP_OFS_DIV:  next_rdata = div;
            SSSP_OFS_STAT: next_rdata = evt;
            SSSP_OFS_MASK: next_rdata = mask;
            default:       next_rdata = 8'h00;
         endcase
      end
   end

   // read data register, zero outside the answer cycle
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   // clock pin driven only with the internal source
   assign sck_out  = gen_sck;
   assign sck_oe_n = ctl.src_ext;
   assign so_out   = so_q;
   assign irq      = |(evt & mask);

endmodule : sssp_core
`default_nettype wire

// >>> test/sssp_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sssp_monitor
   import sssp_pkg::*;
(
   // clock and reset
   input wire logic       mclk,
   input wire logic       srst,
   // register port
   input wire sssp_bus_s  bus,
   input wire logic [7:0] rdata,
   // serial pins and interrupt
   input wire logic       si_in,
   input wire logic       sck_in,
   input wire logic       sck_out,
   input wire logic       sck_oe_n,
   input wire logic       so_out,
   input wire logic       irq
);
   // -------------------------------------------------------------------
   // register mirrors and cycle counters
   // -------------------------------------------------------------------
   logic [7:0] ctl, dv, age, gap;
   logic       sck_q;
   wire        cw = bus.wr && bus.addr == SSSP_OFS_CTRL;

   // age since control write, gap since last clock pin change
   always_ff @(posedge mclk) begin
      sck_q <= sck_out;
      if (srst) begin
         {ctl, dv, age, gap} <= '0;
      end else begin
         ctl <= cw ? bus.wdata : ctl;
         dv  <= (bus.wr && bus.addr == SSSP_OFS_DIV) ? bus.wdata : dv;
         age <= cw ? 8'h00 : age + {7'h00, age != 8'hff};
         // a control write counts from zero: the first edge after a
         // start comes a full half period after the write edge
         gap <= cw ? 8'h00 : (sck_out != sck_q) ? 8'h01 :
                gap + {7'h00, gap != 8'hff};
      end
   end

   // -------------------------------------------------------------------
   // properties
   // -------------------------------------------------------------------
   property p_oe;
      @(posedge mclk) disable iff (srst)
         age > 8'h02 |-> sck_oe_n == ctl[SSSP_CTL_SRC];
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable wrong");
   property p_idle;
      @(posedge mclk) disable iff (srst)
         !ctl[SSSP_CTL_SEN] && age > 8'h03 |=> $stable(sck_out);
   endproperty
   a_idle: assert property (p_idle) else $error("clock moved");
   property p_rxonly;
      @(posedge mclk) disable iff (srst)
         !ctl[SSSP_CTL_TXRX] && age > 8'h03 |=> $stable(so_out);
   endproperty
   a_rxonly: assert property (p_rxonly) else $error("so moved");
   property p_rd0;
      @(posedge mclk) disable iff (srst) !bus.rd |=> rdata == 8'h00;
   endproperty
   a_rd0: assert property (p_rd0) else $error("stray read data");
   property p_start0;
      @(posedge mclk) disable iff (srst)
         bus.rd && bus.addr == SSSP_OFS_CTRL |=> !rdata[SSSP_CTL_START];
   endproperty
   a_start0: assert property (p_start0) else $error("start bit");
   property p_irq;
      @(posedge mclk) disable iff (srst) $rose(irq) |-> ctl[SSSP_CTL_IEN];
   endproperty
   a_irq: assert property (p_irq) else $error("irq not enabled");
   property p_rst;
      @(posedge mclk) disable iff (srst) $fell(srst) |->
         rdata == 8'h00 && !irq && !sck_oe_n && sck_out && !so_out;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_rate;
      @(posedge mclk) disable iff (srst)
         sck_out != sck_q && !sck_oe_n && gap > 8'h02 |->
            {1'b0, gap} == {dv, 1'b0} + 9'h002;
   endproperty
   a_rate: assert property (p_rate) else $error("clock rate");
endmodule : sssp_monitor

bind sssp_core sssp_monitor u_mon (.mclk(mclk), .srst(srst), .bus(bus),
   .rdata(rdata), .si_in(si_in), .sck_in(sck_in), .sck_out(sck_out),
   .sck_oe_n(sck_oe_n), .so_out(so_out), .irq(irq));
`default_nettype wire

// >>> test/sssp_peer.sv
`timescale 1ns/10ps
`default_nettype none
module sssp_peer (
   // link pins
   input  wire logic       sck,
   input  wire logic       so,
   output logic            si,
   // settings and data
   input  wire logic       arm,
   input  wire logic       edge_sel,
   input  wire logic       lsb_first,
   input  wire logic [7:0] tx_byte,
   output logic [7:0]      rx_byte
);
   logic [3:0] n = 4'h0;
   initial si = 1'b0;
   initial rx_byte = 8'h00;

   // drive on the drive edge, sample on the other, count eight bits
   always @(sck or posedge arm) begin
      if (arm) begin
         n = 4'h0;
      end else if (sck === edge_sel) begin
         si = tx_byte[lsb_first ? n[2:0] : 3'h7 - n[2:0]];
      end else begin
         rx_byte[lsb_first ? n[2:0] : 3'h7 - n[2:0]] = so;
         n = n + 4'h1;
      end
   end
endmodule : sssp_peer
`default_nettype wire

// >>> test/tb_sssp_core.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sssp_core
   import sssp_pkg::*;
();
   logic       mclk = 1'b0, srst = 1'b1, ext = 1'b1, arm = 1'b0;
   sssp_bus_s  bus = '0;
   logic [7:0] rdata, prx, d, pd = 8'h00, c = 8'h00;
   logic       si, sck_out, sck_oe_n, so, irq;
   int         n_errors = 0, cmp_count = 0;
   logic [7:0] cfg [5] = '{8'h24, 8'h64, 8'h34, 8'h04, 8'ha4};
   wire        sck = sck_oe_n ? ext : sck_out;

   sssp_core dut (.mclk(mclk), .srst(srst), .bus(bus), .rdata(rdata),
      .si_in(si), .sck_in(sck), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
      .so_out(so), .irq(irq));
   sssp_peer peer (.sck(sck), .so(so), .si(si), .arm(arm), .edge_sel(c[4]),
      .lsb_first(c[6]), .tx_byte(pd), .rx_byte(prx));

   // -------------------------------------------------------------------
   // clock, bus tasks, verdict
   // -------------------------------------------------------------------
   initial forever #5 mclk = ~mclk;

   task automatic chk(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, v);
      @(posedge mclk) bus <= '{a, v, 1'b1, 1'b0};
      @(posedge mclk) bus <= '0;
   endtask : wr

   task automatic rd(input logic [7:0] a, exp);
      @(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk) bus <= '0;
      #1 chk(rdata, exp);
   endtask : rd

   task automatic print_verdict;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   // watchdog against a hung transfer
   initial begin
      #50000;
      n_errors++;
      print_verdict();
   end

   // reset values, then one byte per configuration
   initial begin
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      for (int a = 8'he6; a < 8'hed; a++) rd(8'(a), 8'h00);
      wr(8'he6, 8'hff);
      rd(8'he6, 8'h00);
      wr(SSSP_OFS_DIV, 8'h01);
      rd(SSSP_OFS_DIV, 8'h01);
      wr(SSSP_OFS_MASK, 8'h01);
      for (int i = 0; i < 5; i++) begin
         c = cfg[i];
         d = 8'hc3 ^ 8'(i);
         pd = 8'h5a + 8'(i);
         wr(SSSP_OFS_CTRL, c);
         arm <= 1'b1;
         wr(SSSP_OFS_DATA, d);
         arm <= 1'b0;
         wr(SSSP_OFS_CTRL, c | 8'h0a);
         wr(SSSP_OFS_DATA, 8'hff);
         if (c[7]) repeat (16) begin
            repeat (4) @(posedge mclk);
            ext <= ~ext;
         end
         for (int k = 0; k < 300 && irq !== 1'b1; k++) @(posedge mclk) #1;
         chk({7'h00, irq}, 8'h01);
         rd(SSSP_OFS_CTRL, c | 8'h03);
         rd(SSSP_OFS_DATA, pd);
         if (c[5]) chk(prx, d);
         wr(SSSP_OFS_MASK, 8'h00);
         @(posedge mclk) #1 chk({7'h00, irq}, 8'h00);
         wr(SSSP_OFS_MASK, 8'h01);
         rd(SSSP_OFS_STAT, 8'h03);
         rd(SSSP_OFS_STAT, 8'h00);
         chk({7'h00, irq}, 8'h00);
         wr(SSSP_OFS_CTRL, c | 8'h02);
         rd(SSSP_OFS_CTRL, c | 8'h02);
      end
      print_verdict();
   end
endmodule : tb_sssp_core
`default_nettype wire
